// [design/instruction_deadman_timer.sv]
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module instruction_deadman_timer
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // configuration settings and core activity
  input  wire logic [15:0] max_count_setting_low_i,
  input  wire logic [15:0] max_count_setting_high_i,
  input  wire logic        timer_disable_setting_i,
  input  wire logic        instr_retired_i,
  input  wire logic        clear_window_open_i,
  // outputs
  output logic             timeout_event_o,
  output logic             irq_o
);

  // reset asserts at once but lifts on the clock, so no flop sees a ragged release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  deadman_pkg::reg_req_t req;
  deadman_pkg::cfg_t     cfg;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  // timer disabled by setting: fuse-style level, steady while running
  assign cfg = '{low: max_count_setting_low_i, high: max_count_setting_high_i,
                 disable_n: !timer_disable_setting_i};

  // window input may come from another domain: three flops, agree on the last two
  logic [2:0] win_sync;
  logic       win;
  logic       next_win;

  always_comb
  begin
    next_win = win;
    if (win_sync[2] == win_sync[1])
      next_win = win_sync[2];
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_sync <= 3'b000;
      win      <= 1'b0;
    end
    else if (ce_i)
    begin
      win_sync <= {win_sync[1:0], clear_window_open_i};
      win      <= next_win;
    end
  end

  // strobe plus address match, shared by every write decode and the count-read hold load
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
    hit = s && (a == off);
  endfunction

  logic        on_bit;
  logic [7:0]  first_key;
  logic [7:0]  second_key;
  logic        bad_first_key_flag;
  logic        bad_second_key_flag;
  logic        tmo;
  logic [31:0] counter;
  logic [15:0] hold;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_en;
  logic        next_on_bit;
  logic [7:0]  next_first_key;
  logic [7:0]  next_second_key;
  logic        next_bad_first_key_flag;
  logic        next_bad_second_key_flag;
  logic        next_tmo;
  logic [31:0] next_counter;
  logic [15:0] next_hold;
  logic [2:0]  next_irq_stat;
  logic [2:0]  next_irq_en;
  logic        running;
  logic        wr_first;
  logic        wr_second;
  logic        bad_first_w;
  logic        bad_second_w;
  logic        good_clear;
  logic        expire;
  logic        reset_event;
  logic [31:0] max_count;

  assign max_count    = {cfg.high, cfg.low};
  assign running      = on_bit && cfg.disable_n;
  assign wr_first     = hit(req.addr, deadman_pkg::preclear_off, req.wr);
  assign wr_second    = hit(req.addr, deadman_pkg::clear_off, req.wr);
  assign bad_first_w  = wr_first &&
                        req.wdata[15:8] != deadman_pkg::first_key_value;
  // the clear only counts behind an armed first key; a lone second key is bad
  assign good_clear   = wr_second && req.wdata[7:0] == deadman_pkg::second_key_value &&
                        first_key == deadman_pkg::first_key_value;
  assign bad_second_w = wr_second && !good_clear;
  // compared before the increment, so the count can never slip past the maximum
  assign expire       = running && counter == max_count;
  // a wrong key while running is treated as a timer event just like expiry
  assign reset_event  = expire || (running && (bad_first_w || bad_second_w));

  always_comb
  begin
    next_on_bit     = on_bit;
    next_first_key  = first_key;
    next_second_key = second_key;
    // bad key flags stay set until reset; no software clear exists
    next_bad_first_key_flag       = bad_first_key_flag || bad_first_w;
    next_bad_second_key_flag       = bad_second_key_flag || bad_second_w;
    next_tmo        = tmo || reset_event;
    next_counter    = counter;
    next_hold       = hold;
    next_irq_en     = irq_en;
    next_irq_stat   = irq_stat;
    if (hit(req.addr, deadman_pkg::ctrl_off, req.wr))
      next_on_bit = req.wdata[deadman_pkg::ctrl_on_bit];
    if (hit(req.addr, deadman_pkg::irq_en_off, req.wr))
      next_irq_en = req.wdata[2:0];
    if (wr_first)
      next_first_key = req.wdata[15:8];
    if (wr_second)
      next_second_key = req.wdata[7:0];
    // instructions retired while disabled or frozen are not counted
    if (running && instr_retired_i)
      next_counter = counter + 32'h0000_0001;
    if (good_clear)
    begin
      next_first_key  = 8'h00;
      next_second_key = 8'h00;
      next_counter    = deadman_pkg::zero32;
    end
    // a reset event outranks a good clear and any key load in the same cycle
    if (reset_event)
    begin
      next_first_key  = 8'h00;
      next_second_key = 8'h00;
      next_counter    = deadman_pkg::zero32;
    end
    // either count half read latches the upper half as it stood
    if (hit(req.addr, deadman_pkg::cnt_low_off, req.rd) ||
        hit(req.addr, deadman_pkg::cnt_high_off, req.rd))
      next_hold = counter[31:16];
    // clear first, then set, so a same-cycle event survives
    if (hit(req.addr, deadman_pkg::irq_clr_off, req.wr))
      next_irq_stat = irq_stat & ~req.wdata[2:0];
    if (bad_first_w)
      next_irq_stat[deadman_pkg::irq_bad_first_key_flag] = 1'b1;
    if (bad_second_w)
      next_irq_stat[deadman_pkg::irq_bad_second_key_flag] = 1'b1;
    if (reset_event)
      next_irq_stat[deadman_pkg::irq_tmo] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_bit     <= 1'b0;
      first_key  <= 8'h00;
      second_key <= 8'h00;
      bad_first_key_flag       <= 1'b0;
      bad_second_key_flag       <= 1'b0;
      tmo        <= 1'b0;
      counter    <= deadman_pkg::zero32;
      hold       <= deadman_pkg::zero16;
      irq_stat   <= 3'b000;
      irq_en     <= 3'b000;
    end
    else if (ce_i)
    begin
      on_bit     <= next_on_bit;
      first_key  <= next_first_key;
      second_key <= next_second_key;
      bad_first_key_flag       <= next_bad_first_key_flag;
      bad_second_key_flag       <= next_bad_second_key_flag;
      tmo        <= next_tmo;
      counter    <= next_counter;
      hold       <= next_hold;
      irq_stat   <= next_irq_stat;
      irq_en     <= next_irq_en;
    end
  end

  // read data, valid the cycle after the read strobe
  logic [15:0] status_word;
  logic [15:0] read_mux;
  logic [15:0] next_rdata;

  always_comb
  begin
    status_word = deadman_pkg::zero16;
    status_word[deadman_pkg::bad_first_key_flag_bit]   = bad_first_key_flag;
    status_word[deadman_pkg::bad_second_key_flag_bit]   = bad_second_key_flag;
    status_word[deadman_pkg::event_bit]  = tmo;
    status_word[deadman_pkg::window_bit] = win;
    // unmapped reads give zero so software can probe the map safely
    case (req.addr)
      deadman_pkg::ctrl_off:        read_mux = {on_bit, 15'h0000};
      deadman_pkg::preclear_off:    read_mux = {first_key, 8'h00};
      deadman_pkg::clear_off:       read_mux = {8'h00, second_key};
      deadman_pkg::status_off:      read_mux = status_word;
      deadman_pkg::cnt_low_off:     read_mux = counter[15:0];
      deadman_pkg::cnt_high_off:    read_mux = counter[31:16];
      deadman_pkg::hold_off:        read_mux = hold;
      deadman_pkg::mirror_low_off:  read_mux = cfg.low;
      deadman_pkg::mirror_high_off: read_mux = cfg.high;
      deadman_pkg::irq_stat_off:    read_mux = {13'h0000, irq_stat};
      deadman_pkg::irq_en_off:      read_mux = {13'h0000, irq_en};
      default:                      read_mux = deadman_pkg::zero16;
    endcase
    next_rdata = req.rd ? read_mux : deadman_pkg::zero16;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= deadman_pkg::zero16;
    else if (ce_i)
      rdata_o <= next_rdata;
  end

  logic next_event_o;
  assign next_event_o = reset_event;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timeout_event_o <= 1'b0;
    else if (ce_i)
      timeout_event_o <= next_event_o;
  end

  // level output: high until software clears the status bit or its enable
  assign irq_o = |(irq_stat & irq_en);

  // key sequence
  good_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && good_clear && !reset_event |=> counter == 32'h0000_0000 && first_key == 8'h00)
    else $error("good clear did not zero counter and key");

  clear_keys_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && good_clear |=> second_key == 8'h00)
    else $error("good clear did not zero second key");

  bad_second_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && bad_second_w |=> bad_second_key_flag && ($past(reset_event) || first_key == $past(first_key)))
    else $error("bad second key not flagged");

  second_store_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && bad_second_w && !reset_event |=> second_key == $past(wdata_i[7:0]))
    else $error("bad second key value not stored");

  second_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && reset_event |=> second_key == 8'h00)
    else $error("second key not cleared on reset event");

  first_key_arm_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && wr_first && !bad_first_w && !reset_event |=> first_key == deadman_pkg::first_key_value)
    else $error("good first key not armed");

  first_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && reset_event |=> first_key == 8'h00)
    else $error("first key not cleared on reset event");

  // status readback
  bad_first_key_flag_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && bad_first_w |=> bad_first_key_flag)
    else $error("bad first key not flagged");

  bad_first_key_flag_status_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && rd_i && addr_i == deadman_pkg::status_off |=> rdata_o[deadman_pkg::bad_first_key_flag_bit] == $past(bad_first_key_flag))
    else $error("bad first key not shown in status");

  bad_second_key_flag_status_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && rd_i && addr_i == deadman_pkg::status_off |=> rdata_o[deadman_pkg::bad_second_key_flag_bit] == $past(bad_second_key_flag))
    else $error("bad second key not shown in status");

  event_status_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && rd_i && addr_i == deadman_pkg::status_off |=> rdata_o[deadman_pkg::event_bit] == $past(tmo))
    else $error("event flag not shown in status");

  window_status_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && rd_i && addr_i == deadman_pkg::status_off |=> rdata_o[deadman_pkg::window_bit] == $past(win))
    else $error("window state not shown in status");

  // counter, hold and mirror
  event_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && expire |=> tmo && counter == 32'h0000_0000 && timeout_event_o)
    else $error("expiry did not raise event");

  count_low_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == deadman_pkg::cnt_low_off && ce_i |=> rdata_o == $past(counter[15:0]))
    else $error("low count read wrong");

  count_high_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == deadman_pkg::cnt_high_off && ce_i |=> rdata_o == $past(counter[31:16]))
    else $error("high count read wrong");

  hold_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !(rd_i && (addr_i == deadman_pkg::cnt_low_off || addr_i == deadman_pkg::cnt_high_off)) |=> $stable(hold))
    else $error("hold changed without count read");

  hold_load_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == deadman_pkg::cnt_high_off && ce_i |=> hold == $past(counter[31:16]))
    else $error("hold not loaded on count read");

  hold_low_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == deadman_pkg::cnt_low_off && ce_i |=> hold == $past(counter[31:16]))
    else $error("hold not loaded on low count read");

  mirror_low_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && rd_i && addr_i == deadman_pkg::mirror_low_off |=> rdata_o == $past(max_count_setting_low_i))
    else $error("low max count mirror wrong");

  max_count_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && running && counter == {max_count_setting_high_i, max_count_setting_low_i} |=> tmo && timeout_event_o)
    else $error("match with max count missed");

  stopped_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !running && !good_clear |=> $stable(counter))
    else $error("counter moved while not running");

  enable_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && timer_disable_setting_i && instr_retired_i && !good_clear |=> $stable(counter))
    else $error("counter moved while disabled by setting");

  count_step_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && running && instr_retired_i && !reset_event && !good_clear |=> counter == $past(counter) + 32'h0000_0001)
    else $error("counter did not advance by one");

  event_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i |=> timeout_event_o == $past(reset_event))
    else $error("event output not a pulse per event");

  freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !ce_i |=> $stable(counter) && $stable(hold))
    else $error("state moved while clock enable low");

endmodule

// [design/deadman_pkg.sv]
package deadman_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ctrl_off        = 8'h5c;
  localparam logic [7:0] preclear_off    = 8'h60;
  localparam logic [7:0] clear_off       = 8'h64;
  localparam logic [7:0] status_off      = 8'h68;
  localparam logic [7:0] cnt_low_off     = 8'h6c;
  localparam logic [7:0] cnt_high_off    = 8'h6e;
  localparam logic [7:0] hold_off        = 8'h70;
  localparam logic [7:0] mirror_low_off  = 8'h74;
  localparam logic [7:0] mirror_high_off = 8'h76;
  localparam logic [7:0] irq_stat_off    = 8'h80;
  localparam logic [7:0] irq_en_off      = 8'h82;
  localparam logic [7:0] irq_clr_off     = 8'h84;

  // field positions
  localparam int ctrl_on_bit    = 15;
  localparam int bad_first_key_flag_bit       = 7;
  localparam int bad_second_key_flag_bit       = 6;
  localparam int event_bit      = 5;
  localparam int window_bit     = 0;
  localparam int preclear_lsb   = 8;

  // key values
  localparam logic [7:0] first_key_value  = 8'h40;
  localparam logic [7:0] second_key_value = 8'h08;

  // reset values
  localparam logic [15:0] zero16 = 16'h0000;
  localparam logic [31:0] zero32 = 32'h0000_0000;

  // interrupt sources: bad first key, bad second key, timeout
  localparam int irq_bad_first_key_flag  = 0;
  localparam int irq_bad_second_key_flag  = 1;
  localparam int irq_tmo   = 2;
  localparam int irq_width = 3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
    logic        disable_n;
  } cfg_t;

endpackage

// [verification/tb_deadman_timer_clear_status.sv]
`timescale 1ns/1ns
module tb_deadman_timer_clear_status;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] max_lo = 16'h0010;
  logic [15:0] max_hi = 16'h0000;
  logic        dis_set = 1'b0;
  logic        instr = 1'b0;
  logic        window = 1'b0;
  logic        timeout_event_o;
  logic        irq_o;
  int          errors = 0;
  int          n_checks = 0;

  instruction_deadman_timer instruction_deadman_timer_inst
  (
    .clk_i                    (clk_i),
    .resetn_i                 (resetn_i),
    .ce_i                     (ce_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .max_count_setting_low_i  (max_lo),
    .max_count_setting_high_i (max_hi),
    .timer_disable_setting_i  (dis_set),
    .instr_retired_i          (instr),
    .clear_window_open_i      (window),
    .timeout_event_o          (timeout_event_o),
    .irq_o                    (irq_o)
  );

  always #2 clk_i = ~clk_i;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    check(name, rdata_o, exp);
  endtask

  task automatic run(input logic [31:0] n);
    @(posedge clk_i);
    instr <= 1'b1;
    repeat (n - 1) @(posedge clk_i);
    @(posedge clk_i);
    instr <= 1'b0;
  endtask

  // the event output is a one-cycle pulse, so poll every cycle with a bound
  task automatic wait_evt();
    int k;
    k = 0;
    #1;
    while (timeout_event_o !== 1'b1 && k < 8)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check("timeout event", {15'h0000, timeout_event_o}, 16'h0001);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  initial
  begin
    #(4 * 90000);
    errors++;
    test_done();
  end

  initial
  begin
    do_reset();
    rd("status", deadman_pkg::status_off, 16'h0000);
    rd("count low", deadman_pkg::cnt_low_off, 16'h0000);
    rd("count high", deadman_pkg::cnt_high_off, 16'h0000);
    rd("hold", deadman_pkg::hold_off, 16'h0000);
    rd("mirror low", deadman_pkg::mirror_low_off, 16'h0010);
    rd("unmapped", 8'h90, 16'h0000);
    @(posedge clk_i);
    dis_set <= 1'b1;
    wr(deadman_pkg::ctrl_off, 16'h8000);
    run(32'h0000_0005);
    rd("count disabled", deadman_pkg::cnt_low_off, 16'h0000);
    @(posedge clk_i);
    dis_set <= 1'b0;
    run(32'h0000_000f);
    rd("count live", deadman_pkg::cnt_low_off, 16'h000f);
    run(32'h0000_0001);
    wait_evt();
    rd("status expiry", deadman_pkg::status_off, 16'h0020);
    rd("count restart", deadman_pkg::cnt_low_off, 16'h0000);
    run(32'h0000_0003);
    wr(deadman_pkg::preclear_off, {deadman_pkg::first_key_value, 8'h00});
    wr(deadman_pkg::clear_off, {8'h00, deadman_pkg::second_key_value});
    rd("count cleared", deadman_pkg::cnt_low_off, 16'h0000);
    rd("second key", deadman_pkg::clear_off, 16'h0000);
    rd("first key", deadman_pkg::preclear_off, 16'h0000);
    rd("status good keys", deadman_pkg::status_off, 16'h0020);
    @(posedge clk_i);
    window <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd("status window", deadman_pkg::status_off, 16'h0021);
    @(posedge clk_i);
    window <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd("status closed", deadman_pkg::status_off, 16'h0020);
    wr(deadman_pkg::irq_en_off, 16'h0007);
    #1;
    check("irq raised", {15'h0000, irq_o}, 16'h0001);
    wr(deadman_pkg::irq_clr_off, 16'h0004);
    #1;
    check("irq cleared", {15'h0000, irq_o}, 16'h0000);
    wr(deadman_pkg::preclear_off, 16'h1200);
    wait_evt();
    rd("status bad first", deadman_pkg::status_off, 16'h00a0);
    rd("first key dropped", deadman_pkg::preclear_off, 16'h0000);
    rd("irq status", deadman_pkg::irq_stat_off, 16'h0005);
    wr(deadman_pkg::irq_en_off, 16'h0000);
    #1;
    check("irq masked", {15'h0000, irq_o}, 16'h0000);
    wr(deadman_pkg::irq_clr_off, 16'h0007);
    rd("irq status clr", deadman_pkg::irq_stat_off, 16'h0000);
    wr(deadman_pkg::ctrl_off, 16'h0000);
    wr(deadman_pkg::preclear_off, {deadman_pkg::first_key_value, 8'h00});
    wr(deadman_pkg::clear_off, 16'h0055);
    rd("status bad second", deadman_pkg::status_off, 16'h00e0);
    rd("second key kept", deadman_pkg::clear_off, 16'h0055);
    rd("first key kept", deadman_pkg::preclear_off, 16'h4000);
    wr(deadman_pkg::ctrl_off, 16'h8000);
    wr(deadman_pkg::clear_off, 16'h0033);
    wait_evt();
    rd("second key reset", deadman_pkg::clear_off, 16'h0000);
    // second reset, then cross the 16-bit boundary of the counter
    @(posedge clk_i);
    max_hi <= 16'h0002;
    do_reset();
    rd("status after reset", deadman_pkg::status_off, 16'h0000);
    wr(deadman_pkg::ctrl_off, 16'h8000);
    run(32'h0001_0004);
    rd("hold untouched", deadman_pkg::hold_off, 16'h0000);
    rd("count low wide", deadman_pkg::cnt_low_off, 16'h0004);
    rd("hold loaded", deadman_pkg::hold_off, 16'h0001);
    rd("count high wide", deadman_pkg::cnt_high_off, 16'h0001);
    rd("mirror high", deadman_pkg::mirror_high_off, 16'h0002);
    // instructions retired while the clock enable is low must not count
    @(posedge clk_i);
    ce_i <= 1'b0;
    run(32'h0000_0004);
    ce_i <= 1'b1;
    rd("count frozen", deadman_pkg::cnt_low_off, 16'h0004);
    test_done();
  end
endmodule
